// ==== core/pmcc_pkg.sv ====
// Constants and types shared by the power mode and clock controller
package pmcc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAST_WAKE_NS = 5000;
  // Least wake time, rounded up to whole cycles
  localparam int FAST_WAKE_CYC = (FAST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 11;

  // Oscillator codes; bit 1 set marks a slow source
  localparam logic [1:0] SRC_FAST_EXT = 2'h0;
  localparam logic [1:0] SRC_FAST_INT = 2'h1;
  localparam logic [1:0] SRC_SLOW_EXT = 2'h2;
  localparam logic [1:0] SRC_SLOW_INT = 2'h3;
  localparam int NSRC = 4;

  // Prescaler divides by two to the power of this field
  localparam logic [2:0] PRESC_RESET = 3'h3;
  localparam int DIV_W = 7;

  localparam logic [7:0] OFS_SYS_SEL = 8'h00;
  localparam logic [7:0] OFS_PRESC = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_GATE = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_STAT = 8'h18;
  localparam logic [7:0] OFS_EVT_CLR = 8'h1c;
  localparam logic [7:0] OFS_EVT_EN = 8'h20;

  localparam int CFG_GUARD = 0;
  localparam int CFG_FAST_WAKE = 1;
  localparam int CFG_OUT_EN = 2;
  localparam int CFG_OUT_SRC = 3;
  localparam int CFG_RTC_SRC = 5;
  localparam int CFG_DISP_SRC = 7;
  localparam int STAT_SWITCHING = 2;
  localparam int STAT_MODE = 8;

  localparam logic [2:0] CMD_LP_ENTER = 3'h1;
  localparam logic [2:0] CMD_LP_EXIT = 3'h2;
  localparam logic [2:0] CMD_HALT = 3'h3;
  localparam logic [2:0] CMD_AHALT = 3'h4;

  localparam int EVT_FALLBACK = 0;
  localparam int EVT_SWITCHED = 1;
  localparam int EVT_WAKE = 2;
  localparam int EVT_W = 3;

  // Synchroniser lanes: ticks, ready flags, reference ready
  localparam int SY_TICK = 0;
  localparam int SY_RDY = 4;
  localparam int SY_VREF = 8;
  localparam int NSYNC = 9;

  typedef enum logic [6:0] {
    MODE_RUN = 7'h01,
    MODE_WAIT = 7'h02,
    MODE_LPRUN = 7'h04,
    MODE_LPWAIT = 7'h08,
    MODE_AHALT = 7'h10,
    MODE_HALT = 7'h20,
    MODE_HWAKE = 7'h40
  } pmcc_mode_type;
endpackage : pmcc_pkg

// ==== core/pmcc_top.sv ====
// Power mode sequencer, system clock source, prescaler and clock gating
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pmcc_top import pmcc_pkg::*; #(
  parameter int NPER = 8,
  parameter int GUARD_CYC = 1024
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NSRC-1:0] osc_tick_i,
  input wire logic [NSRC-1:0] osc_ready_i,
  input wire logic vref_ready_i,
  input wire logic wfi_i,
  input wire logic wfe_i,
  input wire logic int_irq_i,
  input wire logic ext_irq_i,
  input wire logic core_event_i,
  input wire logic rtc_irq_i,
  input wire logic halt_wake_i,
  input wire logic lp_event_i,
  output logic main_sys_clock_en_o,
  output logic cpu_clk_en_o,
  output logic [NPER-1:0] periph_clk_en_o,
  output logic ram_clk_en_o,
  output logic flash_clk_en_o,
  output logic rtc_clk_en_o,
  output logic disp_clk_en_o,
  output logic regulator_ulp_o,
  output logic clock_output_pin_o,
  output logic irq_o
);
  if (NPER < 1 || NPER > 24) begin : g_chk_nper
    $error("NPER must lie in 1..24");
  end
  if (GUARD_CYC < 2 || GUARD_CYC > 4095) begin : g_chk_guard
    $error("GUARD_CYC must lie in 2..4095");
  end

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    pmcc_mode_type mode;
    logic [1:0] req_src;
    logic [1:0] act_src;
    logic [1:0] rtc_src;
    logic [1:0] disp_src;
    logic [1:0] out_src;
    logic [2:0] presc;
    logic [DIV_W-1:0] div;
    logic guard_en;
    logic fast_wake;
    logic out_en;
    logic [NPER-1:0] gate;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic [11:0] miss_cnt;
    logic [EVT_W-1:0] stat;
    logic [EVT_W-1:0] ien;
    logic wait_rq;
    logic [31:0] rdata;
    logic sys_en;
    logic cpu_en;
    logic [NPER-1:0] per_en;
    logic ram_en;
    logic flash_en;
    logic rtc_en;
    logic disp_en;
    logic ulp;
    logic ck_out;
    logic irq;
  } pmcc_state_type;

  pmcc_state_type q;
  pmcc_state_type next_q;
  logic [NSRC-1:0] src_tick;
  logic [NSRC-1:0] src_rdy;
  logic sys_tick;
  logic wr;
  logic [2:0] cmd;
  logic [EVT_W-1:0] set;
  logic fallback;

  always_comb begin
    logic [31:0] rd;
    logic [DIV_W-1:0] limit;
    logic periph_on;
    rd = 32'h0;
    limit = '0;
    periph_on = 1'b0;
    next_q = q;
    set = '0;
    fallback = 1'b0;
    sys_tick = 1'b0;
    // Pad levels sampled twice; only the settled copies feed logic
    next_q.s1 = {vref_ready_i, osc_ready_i, osc_tick_i};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    src_tick = q.s2[SY_TICK +: NSRC] & ~q.s3[SY_TICK +: NSRC];
    src_rdy = q.s2[SY_RDY +: NSRC];

    // Bus: one wait cycle, write acts on the edge that sees waitrequest low
    wr = avs_write_i && !q.wait_rq;
    cmd = (wr && avs_address_i == OFS_MODE) ? avs_writedata_i[2:0] : 3'h0;
    case (avs_address_i)
      OFS_SYS_SEL: rd[1:0] = q.req_src;
      OFS_PRESC: rd[2:0] = q.presc;
      OFS_CFG: rd[8:0] = {q.disp_src, q.rtc_src, q.out_src, q.out_en, q.fast_wake, q.guard_en};
      OFS_GATE: rd[NPER-1:0] = q.gate;
      OFS_STATUS: begin
        rd[1:0] = q.act_src;
        rd[STAT_SWITCHING] = (q.req_src != q.act_src);
        rd[STAT_MODE +: 7] = q.mode;
      end
      OFS_EVT_STAT: rd[EVT_W-1:0] = q.stat;
      OFS_EVT_EN: rd[EVT_W-1:0] = q.ien;
      default: rd = 32'h0;
    endcase
    if ((avs_read_i || avs_write_i) && q.wait_rq) begin
      next_q.wait_rq = 1'b0;
      next_q.rdata = rd;
    end else begin
      next_q.wait_rq = 1'b1;
    end
    if (wr) begin
      case (avs_address_i)
        // Source changes only requested in run mode; the switch itself waits below
        OFS_SYS_SEL: if (q.mode == MODE_RUN) next_q.req_src = avs_writedata_i[1:0];
        OFS_PRESC: next_q.presc = avs_writedata_i[2:0];
        OFS_CFG: begin
          next_q.guard_en = avs_writedata_i[CFG_GUARD];
          next_q.fast_wake = avs_writedata_i[CFG_FAST_WAKE];
          next_q.out_en = avs_writedata_i[CFG_OUT_EN];
          next_q.out_src = avs_writedata_i[CFG_OUT_SRC +: 2];
          next_q.rtc_src = avs_writedata_i[CFG_RTC_SRC +: 2];
          next_q.disp_src = avs_writedata_i[CFG_DISP_SRC +: 2];
        end
        OFS_GATE: next_q.gate = avs_writedata_i[NPER-1:0];
        OFS_EVT_EN: next_q.ien = avs_writedata_i[EVT_W-1:0];
        default: ;
      endcase
    end

    // Prescaler counts ticks of the active source
    limit = DIV_W'((8'h1 << q.presc) - 8'h1);
    if (src_tick[q.act_src]) begin
      if (q.div >= limit) begin
        next_q.div = '0;
        sys_tick = 1'b1;
      end else begin
        next_q.div = q.div + 1'b1;
      end
    end
    // Switch only on a divided-clock boundary so no pulse is cut short
    if (q.req_src != q.act_src && src_rdy[q.req_src] && sys_tick) begin
      next_q.act_src = q.req_src;
      next_q.div = '0;
      set[EVT_SWITCHED] = 1'b1;
    end
    // Guard: ready lost or no tick for GUARD_CYC cycles
    if (q.guard_en && q.act_src == SRC_FAST_EXT) begin
      next_q.miss_cnt = src_tick[SRC_FAST_EXT] ? 12'h0 : q.miss_cnt + 12'h1;
      if (!src_rdy[SRC_FAST_EXT] || q.miss_cnt >= 12'(GUARD_CYC - 1)) begin
        fallback = 1'b1;
        next_q.act_src = SRC_FAST_INT;
        next_q.req_src = SRC_FAST_INT;
        next_q.div = '0;
        next_q.miss_cnt = 12'h0;
        set[EVT_FALLBACK] = 1'b1;
      end
    end else begin
      next_q.miss_cnt = 12'h0;
    end

    case (q.mode)
      MODE_RUN: begin
        // Low power run needs a settled slow source
        if (cmd == CMD_LP_ENTER && q.act_src[1] && q.req_src == q.act_src) begin
          next_q.mode = MODE_LPRUN;
        end else if (cmd == CMD_HALT) begin
          next_q.mode = MODE_HALT;
        end else if (cmd == CMD_AHALT) begin
          next_q.mode = MODE_AHALT;
        end else if (wfi_i || wfe_i) begin
          next_q.mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (int_irq_i || ext_irq_i || core_event_i) begin
          next_q.mode = MODE_RUN;
          set[EVT_WAKE] = 1'b1;
        end
      end
      MODE_LPRUN: begin
        // Interrupt inputs are not looked at here
        if (cmd == CMD_LP_EXIT) begin
          next_q.mode = MODE_RUN;
        end else if (wfe_i) begin
          next_q.mode = MODE_LPWAIT;
        end
      end
      MODE_LPWAIT: begin
        if (lp_event_i) begin
          next_q.mode = MODE_LPRUN;
          set[EVT_WAKE] = 1'b1;
        end
      end
      MODE_AHALT: begin
        if (rtc_irq_i || ext_irq_i) begin
          next_q.mode = MODE_RUN;
          set[EVT_WAKE] = 1'b1;
        end
      end
      MODE_HALT: begin
        if (ext_irq_i || halt_wake_i) begin
          next_q.mode = MODE_HWAKE;
          next_q.wake_cnt = '0;
        end
      end
      MODE_HWAKE: begin
        next_q.wake_cnt = q.wake_cnt + 1'b1;
        // Fast path trades reference accuracy for a fixed short wake
        if (q.fast_wake ? (q.wake_cnt >= WAKE_CNT_W'(FAST_WAKE_CYC - 1)) : q.s2[SY_VREF]) begin
          next_q.mode = MODE_RUN;
          set[EVT_WAKE] = 1'b1;
        end
      end
      default: next_q.mode = MODE_RUN;
    endcase

    // Gates follow the mode being entered so outputs line up with q.mode
    periph_on = next_q.mode inside {MODE_RUN, MODE_WAIT, MODE_LPRUN, MODE_LPWAIT};
    next_q.sys_en = sys_tick && periph_on;
    next_q.cpu_en = sys_tick && (next_q.mode inside {MODE_RUN, MODE_LPRUN});
    next_q.per_en = {NPER{sys_tick && periph_on}} & q.gate;
    next_q.ram_en = sys_tick && periph_on;
    next_q.flash_en = sys_tick && (next_q.mode inside {MODE_RUN, MODE_WAIT});
    next_q.ulp = next_q.mode inside {MODE_LPRUN, MODE_LPWAIT};
    next_q.rtc_en = src_tick[q.rtc_src] && !(next_q.mode inside {MODE_HALT, MODE_HWAKE});
    next_q.disp_en = src_tick[q.disp_src] && periph_on;
    if (!q.out_en) begin
      next_q.ck_out = 1'b0;
    end else if (src_tick[q.out_src]) begin
      next_q.ck_out = !q.ck_out;
    end
    // Set beats a clear in the same cycle
    next_q.stat = (q.stat & ~((wr && avs_address_i == OFS_EVT_CLR) ? avs_writedata_i[EVT_W-1:0] : '0)) | set;
    next_q.irq = |(next_q.stat & next_q.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= MODE_RUN;
      q.req_src <= SRC_FAST_INT;
      q.act_src <= SRC_FAST_INT;
      q.presc <= PRESC_RESET;
      q.gate <= '1;
      q.wait_rq <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_rq;
  assign main_sys_clock_en_o = q.sys_en;
  assign cpu_clk_en_o = q.cpu_en;
  assign periph_clk_en_o = q.per_en;
  assign ram_clk_en_o = q.ram_en;
  assign flash_clk_en_o = q.flash_en;
  assign rtc_clk_en_o = q.rtc_en;
  assign disp_clk_en_o = q.disp_en;
  assign regulator_ulp_o = q.ulp;
  assign clock_output_pin_o = q.ck_out;
  assign irq_o = q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_halt_fast;
    q.mode == MODE_HWAKE && q.fast_wake;
  endsequence
  sequence s_lp_idle;
    q.mode == MODE_LPRUN && cmd == 3'h0 && !wfe_i;
  endsequence

  wait_cpu_a: assert property (q.mode == MODE_WAIT |-> !cpu_clk_en_o) else $error("cpu clock in wait");
  wait_exit_a: assert property (q.mode == MODE_WAIT && int_irq_i |=> q.mode == MODE_RUN ##0 $past(set[EVT_WAKE]))
    else $error("wait not left on interrupt");
  lp_state_a: assert property (q.mode == MODE_LPRUN |-> !flash_clk_en_o && regulator_ulp_o && q.act_src[1])
    else $error("low power run setup wrong");
  lp_entry_a: assert property (q.mode == MODE_LPRUN && $past(q.mode) == MODE_RUN |-> $past(cmd) == CMD_LP_ENTER)
    else $error("low power run entered without command");
  lp_irq_a: assert property (s_lp_idle ##0 (int_irq_i || ext_irq_i) |=> q.mode == MODE_LPRUN [*1] ##1 1'b1)
    else $error("interrupt left low power run");
  lpw_enter_a: assert property (q.mode == MODE_LPRUN && wfe_i && cmd == 3'h0
    |=> q.mode == MODE_LPWAIT ##0 !cpu_clk_en_o) else $error("wait for event ignored");
  lpw_wake_a: assert property (q.mode == MODE_LPWAIT && lp_event_i |=> q.mode == MODE_LPRUN)
    else $error("event wake not to low power run");
  ahalt_clk_a: assert property (q.mode == MODE_AHALT |-> !cpu_clk_en_o && periph_clk_en_o == '0 && !ram_clk_en_o)
    else $error("clock running in active-halt");
  halt_clk_a: assert property (q.mode == MODE_HALT |-> !cpu_clk_en_o && !rtc_clk_en_o && periph_clk_en_o == '0)
    else $error("clock running in halt");
  fast_hold_a: assert property (s_halt_fast ##0 q.wake_cnt < WAKE_CNT_W'(FAST_WAKE_CYC - 1) |=> q.mode == MODE_HWAKE)
    else $error("fast wake left early");
  fast_done_a: assert property (s_halt_fast ##0 q.wake_cnt == WAKE_CNT_W'(FAST_WAKE_CYC - 1) |=> q.mode == MODE_RUN)
    else $error("fast wake late");
  // The request already names the new source, so its past ready bit is the one that matters
  switch_rdy_a: assert property ($changed(q.act_src) && !$past(fallback)
    |-> $past(src_rdy[q.req_src]) && $past(sys_tick)) else $error("switch to unready source");
  reset_clk_a: assert property ($past(rst_i) |-> q.act_src == SRC_FAST_INT && q.presc == PRESC_RESET)
    else $error("reset clock wrong");
  guard_fall_a: assert property (q.guard_en && q.act_src == SRC_FAST_EXT && !src_rdy[SRC_FAST_EXT]
    |=> q.act_src == SRC_FAST_INT && q.stat[EVT_FALLBACK]) else $error("no fallback");
endmodule : pmcc_top
`default_nettype wire

// ==== tb/pmcc_osc_model.sv ====
// Oscillator and reference voltage models feeding the clock controller
`timescale 1ns/1ps
`default_nettype none
module pmcc_osc_model #(
  parameter int HALF0 = 3,
  parameter int HALF1 = 2,
  parameter int HALF2 = 9,
  parameter int HALF3 = 11
) (
  input wire logic clk_i,
  input wire logic [3:0] osc_off_i,
  input wire logic vref_on_i,
  output logic [3:0] osc_tick_o,
  output logic [3:0] osc_ready_o,
  output logic vref_ready_o
);
  int cnt [4];

  function automatic int half_of(input int i);
    case (i)
      0: return HALF0;
      1: return HALF1;
      2: return HALF2;
      default: return HALF3;
    endcase
  endfunction : half_of

  initial begin
    osc_tick_o = 4'h0;
    for (int i = 0; i < 4; i++) cnt[i] = 0;
  end

  // Two fast and two slow free-running sources; a stopped one freezes its pad level
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (osc_off_i[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] >= half_of(i) - 1) begin
        cnt[i] <= 0;
        osc_tick_o[i] <= ~osc_tick_o[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  // Ready drops at once when a source dies, so a fallback is not masked by a stale flag
  assign osc_ready_o = ~osc_off_i;
  // Reference settle is left to the bench so slow and fast halt wakeups can be told apart
  assign vref_ready_o = vref_on_i;
endmodule : pmcc_osc_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the power mode and clock controller
`timescale 1ns/1ps
`default_nettype none
module tb_top import pmcc_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [3:0] osc_tick, osc_ready, osc_off = 4'h0;
  logic vref_ready, vref_on = 1'b0;
  logic [7:0] ev = 8'h00;
  logic sys_en, cpu_en, ram_en, flash_en, rtc_en, disp_en, ulp, pin, pin_q, irq_o, cnt_clr = 1'b0;
  logic [7:0] per_en;
  int n_sys, n_cpu, n_flash, n_rtc, n_pin, n_per0, n_per1, n_ram, n_disp;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] q;

  always #2 clk_i = ~clk_i;

  pmcc_osc_model i_pmcc_osc_model (.clk_i(clk_i), .osc_off_i(osc_off), .vref_on_i(vref_on),
    .osc_tick_o(osc_tick), .osc_ready_o(osc_ready), .vref_ready_o(vref_ready));

  pmcc_top #(.NPER(8), .GUARD_CYC(64)) i_pmcc_top (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .osc_tick_i(osc_tick), .osc_ready_i(osc_ready), .vref_ready_i(vref_ready), .wfi_i(ev[0]), .wfe_i(ev[1]),
    .int_irq_i(ev[2]), .ext_irq_i(ev[3]), .core_event_i(ev[4]), .rtc_irq_i(ev[5]), .halt_wake_i(ev[6]),
    .lp_event_i(ev[7]), .main_sys_clock_en_o(sys_en), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
    .ram_clk_en_o(ram_en), .flash_clk_en_o(flash_en), .rtc_clk_en_o(rtc_en), .disp_clk_en_o(disp_en),
    .regulator_ulp_o(ulp), .clock_output_pin_o(pin), .irq_o(irq_o));

  // Pulse counters over a measuring window
  always @(posedge clk_i) begin
    pin_q <= pin;
    if (cnt_clr) begin
      {n_sys, n_cpu, n_flash, n_rtc, n_pin, n_per0, n_per1, n_ram, n_disp} <= '0;
    end else begin
      n_sys <= n_sys + int'(sys_en);
      n_cpu <= n_cpu + int'(cpu_en);
      n_flash <= n_flash + int'(flash_en);
      n_rtc <= n_rtc + int'(rtc_en);
      n_pin <= n_pin + int'(pin !== pin_q);
      n_per0 <= n_per0 + int'(per_en[0]);
      n_per1 <= n_per1 + int'(per_en[1]);
      n_ram <= n_ram + int'(ram_en);
      n_disp <= n_disp + int'(disp_en);
    end
  end

  task automatic fail(input string what, input logic [31:0] e, input logic [31:0] s);
    n_mismatch++;
    $display("Error %s expected %h seen %h", what, e, s);
  endtask : fail

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) fail(what, e, s);
  endtask : chk

  task automatic rng(input string what, input int lo, input int hi, input int s);
    comparisons++;
    if (s < lo || s > hi) fail(what, 32'(lo), 32'(s));
  endtask : rng

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= d;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 50) fail("waitrequest", 32'h0, 32'h1);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, q & m);
  endtask : rdc

  task automatic mode_is(input logic [6:0] m);
    rdc("mode", OFS_STATUS, 32'h7f00, {17'h0, m, 8'h00});
  endtask : mode_is

  task automatic src_wait(input logic [1:0] s);
    int k;
    k = 0;
    q = 32'h4;
    while (q[2:0] !== {1'b0, s} && k < 300) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      k++;
    end
    chk("active source", {29'h0, 1'b0, s}, {29'h0, q[2:0]});
  endtask : src_wait

  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic win(input int n);
    @(posedge clk_i);
    cnt_clr <= 1'b1;
    @(posedge clk_i);
    cnt_clr <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : win

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("presc", OFS_PRESC, 32'h7, 32'h3);
    rdc("status", OFS_STATUS, 32'hffffffff, 32'h101);
    rdc("gate", OFS_GATE, 32'hff, 32'hff);
    rdc("cfg", OFS_CFG, 32'hffffffff, 32'h0);
    rdc("unmapped", 8'h24, 32'hffffffff, 32'h0);
    win(640);
    rng("sys per 640", 19, 21, n_sys);
    wr(OFS_PRESC, 32'h0);
    win(640);
    rng("sys undivided", 158, 162, n_sys);
    wr(OFS_PRESC, 32'h3);
    wr(OFS_GATE, 32'h5);
    wr(OFS_CFG, 32'h6c);
    win(400);
    rng("periph0", 1, 20, n_per0);
    chk("periph1", 32'h0, 32'(n_per1));
    rng("clock pin toggles", 99, 101, n_pin);
    rng("rtc on slow rc", 17, 19, n_rtc);
    rng("ram clock", 11, 14, n_ram);
    rng("display on fast crystal", 65, 68, n_disp);
    pulse(0);
    mode_is(7'h02);
    win(100);
    chk("cpu in wait", 32'h0, 32'(n_cpu));
    pulse(2);
    mode_is(7'h01);
    pulse(1);
    pulse(4);
    mode_is(7'h01);
    osc_off[2] <= 1'b1;
    wr(OFS_SYS_SEL, 32'h2);
    win(400);
    rdc("switch pending", OFS_STATUS, 32'h7, 32'h5);
    osc_off[2] <= 1'b0;
    src_wait(2'h2);
    rdc("switched flag", OFS_EVT_STAT, 32'h2, 32'h2);
    wr(OFS_EVT_EN, 32'h2);
    @(posedge clk_i);
    chk("irq set", 32'h1, 32'(irq_o));
    wr(OFS_EVT_CLR, 32'h2);
    @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    wr(OFS_EVT_EN, 32'h0);
    wr(OFS_SYS_SEL, 32'h0);
    src_wait(2'h0);
    wr(OFS_SYS_SEL, 32'h3);
    src_wait(2'h3);
    wr(OFS_MODE, {29'h0, CMD_LP_ENTER});
    mode_is(7'h04);
    chk("regulator", 32'h1, 32'(ulp));
    win(400);
    chk("flash in lp run", 32'h0, 32'(n_flash));
    rng("cpu in lp run", 1, 10, n_cpu);
    pulse(2);
    pulse(3);
    mode_is(7'h04);
    pulse(1);
    mode_is(7'h08);
    win(400);
    chk("cpu in lp wait", 32'h0, 32'(n_cpu));
    pulse(2);
    mode_is(7'h08);
    pulse(7);
    mode_is(7'h04);
    wr(OFS_MODE, {29'h0, CMD_LP_EXIT});
    mode_is(7'h01);
    wr(OFS_SYS_SEL, 32'h1);
    src_wait(2'h1);
    wr(OFS_MODE, {29'h0, CMD_AHALT});
    mode_is(7'h10);
    win(200);
    chk("cpu in active halt", 32'h0, 32'(n_cpu));
    chk("periph in active halt", 32'h0, 32'(n_per0));
    chk("display in active halt", 32'h0, 32'(n_disp));
    rng("rtc in active halt", 7, 11, n_rtc);
    pulse(5);
    mode_is(7'h01);
    wr(OFS_CFG, 32'h6e);
    wr(OFS_MODE, {29'h0, CMD_HALT});
    win(100);
    chk("sys in halt", 32'h0, 32'(n_sys));
    chk("rtc in halt", 32'h0, 32'(n_rtc));
    pulse(3);
    repeat (1150) @(posedge clk_i);
    mode_is(7'h40);
    repeat (150) @(posedge clk_i);
    mode_is(7'h01);
    wr(OFS_CFG, 32'h6c);
    wr(OFS_MODE, {29'h0, CMD_HALT});
    pulse(6);
    repeat (1400) @(posedge clk_i);
    mode_is(7'h40);
    vref_on <= 1'b1;
    repeat (10) @(posedge clk_i);
    mode_is(7'h01);
    wr(OFS_CFG, 32'h6d);
    wr(OFS_SYS_SEL, 32'h0);
    src_wait(2'h0);
    osc_off[0] <= 1'b1;
    src_wait(2'h1);
    rdc("fallback flag", OFS_EVT_STAT, 32'h1, 32'h1);
    wr(OFS_EVT_EN, 32'h1);
    @(posedge clk_i);
    chk("fallback irq", 32'h1, 32'(irq_o));
    test_done();
  end
endmodule : tb_top
`default_nettype wire
